// ==== verilog/mmbe_engine.sv ====
/*
  Matrix mix bus engine: per-sample sum of 36 inputs into stereo bus pairs.
  Assumes samples, commands and the output consumer share REF_CLK.
*/
`timescale 1ns/1ns
module mmbe_engine (
  // Clock and reset
  input  wire logic                             REF_CLK,
  input  wire logic                             RST,
  // Sample stream and mode
  input  wire logic                             SAMPLE_TICK,
  input  wire logic [mmbe_pkg::NCH*mmbe_pkg::SW-1:0] CH_SAMPLES,
  input  wire logic                             DOUBLE_RATE,
  input  wire logic [mmbe_pkg::NLINK-1:0]       STEREO_LINK,
  // Control commands
  input  wire logic                             CMD_VALID,
  input  wire mmbe_pkg::mmbe_cmd_type           CMD_WORD,
  // Mixed output
  output logic                                  MIX_VALID,
  input  wire logic                             MIX_READY,
  output mmbe_pkg::mmbe_mix_type                MIX_WORD,
  // Metering and status
  input  wire logic [5:0]                       METER_SEL,
  output logic [mmbe_pkg::SW-1:0]               METER_PEAK,
  output logic                                  BUSY
);
  typedef enum logic [1:0] {ST_IDLE, ST_CHAN, ST_MASTER} mmbe_state_type;

  // Initial mute of a channel on a bus pair
  function automatic logic init_mute(input int p, input int c);
    return !((c >= mmbe_pkg::NHW) && ((c - mmbe_pkg::NHW) / 2 == p));
  endfunction

  // Constant-power pan law, quarter sine with linear interpolation
  function automatic logic [15:0] pan_law(input logic [7:0] u);
    logic [3:0]  seg;
    logic [4:0]  fr;
    logic [15:0] d;
    logic [20:0] m;
    seg = 4'(u / mmbe_pkg::PAN_SEG);
    fr  = 5'(u % mmbe_pkg::PAN_SEG);
    if (seg >= mmbe_pkg::PAN_LAST_SEG) begin
      return mmbe_pkg::PAN_LAW[10];
    end
    d = mmbe_pkg::PAN_LAW[seg + 4'h1] - mmbe_pkg::PAN_LAW[seg];
    m = d * fr;
    return mmbe_pkg::PAN_LAW[seg] + 16'(m / 21'(mmbe_pkg::PAN_SEG));
  endfunction

  // One sample of linear gain ramp toward an effective target
  function automatic mmbe_pkg::mmbe_ramp_type ramp_adv(
      input mmbe_pkg::mmbe_ramp_type r, input logic [15:0] eff);
    mmbe_pkg::mmbe_ramp_type n;
    logic signed [16:0]      diff;
    n    = r;
    diff = $signed({1'b0, eff}) - $signed({1'b0, r.cur});
    if (eff != r.tgt) begin
      n.tgt  = eff;
      n.step = diff >>> mmbe_pkg::RAMP_LOG2;
      n.cnt  = mmbe_pkg::RAMP_SAMPLES;
      n.cur  = 16'($signed({1'b0, r.cur}) + (diff >>> mmbe_pkg::RAMP_LOG2));
    end else if (r.cnt > 7'h01) begin
      n.cur = 16'($signed({1'b0, r.cur}) + r.step);
      n.cnt = r.cnt - 7'h01;
    end else begin
      n.cur = r.tgt;
      n.cnt = 7'h00;
    end
    return n;
  endfunction

  // Saturate a partial sum to the headroom range
  function automatic logic signed [31:0] sat_head(input logic signed [32:0] s);
    if (s > 33'(mmbe_pkg::HEAD_MAX)) return mmbe_pkg::HEAD_MAX;
    if (s < 33'(mmbe_pkg::HEAD_MIN)) return mmbe_pkg::HEAD_MIN;
    return 32'(s);
  endfunction

  // Apply a master gain and clip to the output word
  function automatic logic signed [23:0] master_out(
      input logic signed [31:0] a, input logic [15:0] g);
    logic signed [48:0] m;
    m = (a * $signed({1'b0, g})) >>> mmbe_pkg::GAIN_FRAC;
    if (m > 49'(mmbe_pkg::OUT_MAX)) return mmbe_pkg::OUT_MAX;
    if (m < 49'(mmbe_pkg::OUT_MIN)) return mmbe_pkg::OUT_MIN;
    return 24'(m);
  endfunction

  // Control state
  logic [15:0]       gain_q [mmbe_pkg::NPAIR][mmbe_pkg::NCH];
  logic [15:0]       gain_d [mmbe_pkg::NPAIR][mmbe_pkg::NCH];
  logic signed [7:0] pan_q  [mmbe_pkg::NPAIR][mmbe_pkg::NCH];
  logic signed [7:0] pan_d  [mmbe_pkg::NPAIR][mmbe_pkg::NCH];
  logic [35:0]       mute_q [mmbe_pkg::NPAIR];
  logic [35:0]       mute_d [mmbe_pkg::NPAIR];
  logic [35:0]       solo_q [mmbe_pkg::NPAIR];
  logic [35:0]       solo_d [mmbe_pkg::NPAIR];
  logic [15:0]       mtgt_q [mmbe_pkg::NBUS];
  logic [15:0]       mtgt_d [mmbe_pkg::NBUS];
  logic [4:0]        bmute_q, bmute_d;
  logic [23:0]       peak_q [mmbe_pkg::NCH];
  logic [23:0]       peak_d [mmbe_pkg::NCH];
  logic [23:0]       meter_q, meter_d;
  // Engine state
  mmbe_state_type          state_q, state_d;
  logic [2:0]              p_q, p_d, np_q, np_d;
  logic [5:0]              c_q, c_d;
  logic signed [31:0]      accl_q, accl_d, accr_q, accr_d;
  logic [15:0]             lead_q, lead_d;
  logic signed [23:0]      samp_q [mmbe_pkg::NCH];
  logic signed [23:0]      samp_d [mmbe_pkg::NCH];
  mmbe_pkg::mmbe_ramp_type cr_q [mmbe_pkg::NPAIR][mmbe_pkg::NCH];
  mmbe_pkg::mmbe_ramp_type cr_d [mmbe_pkg::NPAIR][mmbe_pkg::NCH];
  mmbe_pkg::mmbe_ramp_type mr_q [mmbe_pkg::NBUS];
  mmbe_pkg::mmbe_ramp_type mr_d [mmbe_pkg::NBUS];
  logic                    busy_q, busy_d;
  // Output buffer
  mmbe_pkg::mmbe_mix_type  fm_q [2];
  mmbe_pkg::mmbe_mix_type  fm_d [2];
  logic                    wp_q, wp_d, rp_q, rp_d;
  logic [1:0]              cnt_q, cnt_d;
  logic                    ov_q, ov_d;
  mmbe_pkg::mmbe_mix_type  ow_q, ow_d;
  logic                    push;
  mmbe_pkg::mmbe_mix_type  push_word;

  // Command decode and peak meters
  always_comb begin
    logic [2:0]         cp;
    logic [5:0]         cc;
    logic signed [23:0] s;
    logic [23:0]        a;
    s  = '0;
    a  = '0;
    cp = CMD_WORD.pair;
    cc = CMD_WORD.chan;
    gain_d  = gain_q;
    pan_d   = pan_q;
    mute_d  = mute_q;
    solo_d  = solo_q;
    mtgt_d  = mtgt_q;
    bmute_d = bmute_q;
    peak_d  = peak_q;
    if (CMD_VALID && cp < 3'(mmbe_pkg::NPAIR)
        && cc < 6'(mmbe_pkg::NCH)) begin
      case (CMD_WORD.op)
        mmbe_pkg::OP_GAIN: begin
          gain_d[cp][cc] = (CMD_WORD.value > mmbe_pkg::GAIN_MAX) ?
                           mmbe_pkg::GAIN_MAX : CMD_WORD.value;
        end
        mmbe_pkg::OP_PAN: begin
          if ($signed(CMD_WORD.value[7:0]) < mmbe_pkg::pan_full_left) begin
            pan_d[cp][cc] = mmbe_pkg::pan_full_left;
          end else if ($signed(CMD_WORD.value[7:0])
                       > mmbe_pkg::pan_full_right) begin
            pan_d[cp][cc] = mmbe_pkg::pan_full_right;
          end else begin
            pan_d[cp][cc] = $signed(CMD_WORD.value[7:0]);
          end
        end
        mmbe_pkg::OP_MUTE:     mute_d[cp][cc] = CMD_WORD.value[0];
        mmbe_pkg::OP_SOLO:     solo_d[cp][cc] = CMD_WORD.value[0];
        mmbe_pkg::OP_SOLO_EXCL: begin
          solo_d[cp]     = 36'h0;
          solo_d[cp][cc] = 1'b1;
        end
        mmbe_pkg::OP_MUTE_ALL: mute_d[cp] = {36{CMD_WORD.value[0]}};
        mmbe_pkg::OP_SOLO_ALL: solo_d[cp] = {36{CMD_WORD.value[0]}};
        mmbe_pkg::OP_MASTER: begin
          mtgt_d[{cp, CMD_WORD.side}] = (CMD_WORD.value > mmbe_pkg::GAIN_MAX)
                                      ? mmbe_pkg::GAIN_MAX : CMD_WORD.value;
        end
        mmbe_pkg::OP_BUS_MUTE: bmute_d[cp] = CMD_WORD.value[0];
        mmbe_pkg::OP_PEAK_CLR: peak_d[cc] = 24'h000000;
        default: ;
      endcase
    end
    // A new sample beats a clear in the same cycle
    if (SAMPLE_TICK && state_q == ST_IDLE) begin
      for (int c = 0; c < mmbe_pkg::NCH; c++) begin
        s = $signed(CH_SAMPLES[c*mmbe_pkg::SW +: mmbe_pkg::SW]);
        a = s[23] ? 24'(-s) : 24'(s);
        if (a > peak_d[c]) begin
          peak_d[c] = a;
        end
      end
    end
    meter_d = (METER_SEL < 6'(mmbe_pkg::NCH)) ? peak_q[METER_SEL] : 24'h0;
  end

  // Control registers, reset to the power-on mix
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      for (int p = 0; p < mmbe_pkg::NPAIR; p++) begin
        for (int c = 0; c < mmbe_pkg::NCH; c++) begin
          gain_q[p][c] <= mmbe_pkg::GAIN_UNITY;
          pan_q[p][c]  <= mmbe_pkg::PAN_CENTER;
          mute_q[p][c] <= init_mute(p, c);
        end
        solo_q[p] <= 36'h0;
      end
      for (int b = 0; b < mmbe_pkg::NBUS; b++) begin
        mtgt_q[b] <= mmbe_pkg::GAIN_UNITY;
      end
      for (int c = 0; c < mmbe_pkg::NCH; c++) begin
        peak_q[c] <= 24'h000000;
      end
      bmute_q <= 5'h00;
      meter_q <= 24'h000000;
    end else begin
      gain_q  <= gain_d;
      pan_q   <= pan_d;
      mute_q  <= mute_d;
      solo_q  <= solo_d;
      mtgt_q  <= mtgt_d;
      bmute_q <= bmute_d;
      peak_q  <= peak_d;
      meter_q <= meter_d;
    end
  end

  // Mixing engine: one channel per cycle, then master stage per pair
  always_comb begin
    logic               st;
    logic               odd_st;
    logic               off;
    logic [15:0]        eff;
    logic [15:0]        g;
    logic signed [40:0] prod;
    logic signed [26:0] scl;
    logic signed [43:0] pl;
    logic signed [43:0] pr;
    logic signed [26:0] cl;
    logic signed [26:0] crr;
    logic [3:0]         bl;
    cl  = '0;
    crr = '0;
    state_d = state_q;
    p_d = p_q; np_d = np_q; c_d = c_q;
    accl_d = accl_q; accr_d = accr_q; lead_d = lead_q;
    samp_d = samp_q; cr_d = cr_q; mr_d = mr_q;
    push = 1'b0;
    push_word = '0;
    st = STEREO_LINK[c_q[5:1]];
    odd_st = st && c_q[0];
    off = mute_q[p_q][c_q] || (|solo_q[p_q] && !solo_q[p_q][c_q]);
    eff = off ? mmbe_pkg::GAIN_MUTED : gain_q[p_q][c_q];
    g = odd_st ? lead_q : cr_q[p_q][c_q].cur;
    prod = samp_q[c_q] * $signed({1'b0, g});
    scl = 27'(prod >>> mmbe_pkg::GAIN_FRAC);
    pl = scl * $signed({1'b0, pan_law(mmbe_pkg::PAN_CENTER_U
                                      - 8'(pan_q[p_q][c_q]))});
    pr = scl * $signed({1'b0, pan_law(mmbe_pkg::PAN_CENTER_U
                                      + 8'(pan_q[p_q][c_q]))});
    if (st) begin
      cl  = c_q[0] ? 27'sh0 : scl;
      crr = c_q[0] ? scl : 27'sh0;
    end else begin
      cl  = 27'(pl >>> mmbe_pkg::GAIN_FRAC);
      crr = 27'(pr >>> mmbe_pkg::GAIN_FRAC);
    end
    bl = {p_q, 1'b0};
    case (state_q)
      ST_IDLE: begin
        if (SAMPLE_TICK) begin
          for (int c = 0; c < mmbe_pkg::NCH; c++) begin
            samp_d[c] = $signed(CH_SAMPLES[c*mmbe_pkg::SW +: mmbe_pkg::SW]);
          end
          np_d = DOUBLE_RATE ? 3'(mmbe_pkg::NPAIR_DR)
                             : 3'(mmbe_pkg::NPAIR);
          p_d = 3'h0; c_d = 6'h00;
          accl_d = 32'sh0; accr_d = 32'sh0;
          state_d = ST_CHAN;
        end
      end
      ST_CHAN: begin
        if (!odd_st) begin
          cr_d[p_q][c_q] = ramp_adv(cr_q[p_q][c_q], eff);
        end
        lead_d = g;
        accl_d = sat_head(33'(accl_q) + 33'(cl));
        accr_d = sat_head(33'(accr_q) + 33'(crr));
        if (c_q == 6'(mmbe_pkg::NCH - 1)) begin
          state_d = ST_MASTER;
        end else begin
          c_d = c_q + 6'h01;
        end
      end
      ST_MASTER: begin
        if (cnt_q != 2'h2) begin
          push = 1'b1;
          push_word.pair  = p_q;
          push_word.left  = master_out(accl_q, mr_q[bl].cur);
          push_word.right = master_out(accr_q, mr_q[bl + 4'h1].cur);
          for (int s = 0; s < 2; s++) begin
            mr_d[bl + 4'(s)] = ramp_adv(mr_q[bl + 4'(s)],
                bmute_q[p_q] ? mmbe_pkg::GAIN_MUTED
                             : mtgt_q[bl + 4'(s)]);
          end
          if (p_q == np_q - 3'h1) begin
            state_d = ST_IDLE;
          end else begin
            p_d = p_q + 3'h1; c_d = 6'h00;
            accl_d = 32'sh0; accr_d = 32'sh0;
            state_d = ST_CHAN;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
    busy_d = (state_d != ST_IDLE);
  end

  // Engine registers; ramps start settled on the power-on targets
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
      p_q <= 3'h0; np_q <= 3'h0; c_q <= 6'h00;
      accl_q <= 32'sh0; accr_q <= 32'sh0; lead_q <= 16'h0;
      busy_q <= 1'b0;
      for (int c = 0; c < mmbe_pkg::NCH; c++) begin
        samp_q[c] <= 24'sh0;
      end
      for (int p = 0; p < mmbe_pkg::NPAIR; p++) begin
        for (int c = 0; c < mmbe_pkg::NCH; c++) begin
          cr_q[p][c].tgt  <= init_mute(p, c) ? mmbe_pkg::GAIN_MUTED
                                             : mmbe_pkg::GAIN_UNITY;
          cr_q[p][c].cur  <= init_mute(p, c) ? mmbe_pkg::GAIN_MUTED
                                             : mmbe_pkg::GAIN_UNITY;
          cr_q[p][c].step <= 17'sh0;
          cr_q[p][c].cnt  <= 7'h00;
        end
      end
      for (int b = 0; b < mmbe_pkg::NBUS; b++) begin
        mr_q[b] <= '{mmbe_pkg::GAIN_UNITY, 17'sh0, 7'h00,
                     mmbe_pkg::GAIN_UNITY};
      end
    end else begin
      state_q <= state_d;
      p_q <= p_d; np_q <= np_d; c_q <= c_d;
      accl_q <= accl_d; accr_q <= accr_d; lead_q <= lead_d;
      busy_q <= busy_d;
      samp_q <= samp_d;
      cr_q <= cr_d;
      mr_q <= mr_d;
    end
  end

  // Two-entry output buffer; a full buffer stalls the master stage
  always_comb begin
    logic pop;
    pop  = ov_q && MIX_READY;
    fm_d = fm_q;
    wp_d = wp_q;
    rp_d = rp_q;
    if (push) begin
      fm_d[wp_q] = push_word;
      wp_d = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    cnt_d = cnt_q + 2'(push) - 2'(pop);
    ov_d  = (cnt_d != 2'h0);
    ow_d  = fm_d[rp_d];
  end

  // Buffer registers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      fm_q[0] <= '0;
      fm_q[1] <= '0;
      wp_q <= 1'b0; rp_q <= 1'b0; cnt_q <= 2'h0;
      ov_q <= 1'b0; ow_q <= '0;
    end else begin
      fm_q <= fm_d;
      wp_q <= wp_d; rp_q <= rp_d; cnt_q <= cnt_d;
      ov_q <= ov_d; ow_q <= ow_d;
    end
  end

  // Registered outputs
  assign MIX_VALID  = ov_q;
  assign MIX_WORD   = ow_q;
  assign METER_PEAK = meter_q;
  assign BUSY       = busy_q;
endmodule

// ==== verilog/mmbe_pkg.sv ====
/*
  Shared constants and types for the matrix mix bus engine.
  Assumes the engine and its bench both refer to names as mmbe_pkg::name.
*/
package mmbe_pkg;
  // Channel and bus counts
  localparam int NCH      = 36;          // Inputs per bus
  localparam int NHW      = 18;          // Hardware inputs, playback follows
  localparam int NLINK    = 18;          // Channel pairs that may be stereo
  localparam int NPAIR    = 5;           // Stereo bus pairs at single rate
  localparam int NPAIR_DR = 2;           // Stereo bus pairs at double rate
  localparam int NBUS     = 10;          // Mono buses at single rate
  // Data widths
  localparam int SW       = 24;          // Sample width
  localparam int GW       = 16;          // Gain width, unsigned Q2.14
  localparam int ACCW     = 32;          // Bus accumulator width
  // Gain coding
  localparam int             GAIN_FRAC  = 14;
  localparam logic [GW-1:0]  GAIN_MUTED = 16'h0000;
  localparam logic [GW-1:0]  GAIN_UNITY = 16'h4000;
  localparam logic [GW-1:0]  GAIN_MAX   = 16'hca62;  // +10 dB
  // Gain ramp: linear over 2**RAMP_LOG2 samples
  localparam int             RAMP_LOG2    = 6;
  localparam logic [6:0]     RAMP_SAMPLES = 7'h40;
  // Summing headroom: 24 dB above full scale is four extra bits
  localparam logic signed [ACCW-1:0] HEAD_MAX = 32'sh07ffffff;
  localparam logic signed [ACCW-1:0] HEAD_MIN = 32'shf8000000;
  localparam logic signed [SW-1:0]   OUT_MAX  = 24'sh7fffff;
  localparam logic signed [SW-1:0]   OUT_MIN  = 24'sh800000;
  // Pan coding, signed position
  localparam logic signed [7:0] pan_full_left  = -8'sh64;
  localparam logic signed [7:0] pan_full_right = 8'sh64;
  localparam logic signed [7:0] PAN_CENTER     = 8'sh00;
  localparam logic [7:0]        PAN_CENTER_U   = 8'h64;
  localparam logic [7:0]        PAN_SEG        = 8'h14;
  localparam logic [3:0]        PAN_LAST_SEG   = 4'ha;
  // Quarter sine in Q2.14 at every PAN_SEG steps of position
  localparam logic [GW-1:0] PAN_LAW [11] = '{16'h0000, 16'h0a03, 16'h13c7,
    16'h1d0e, 16'h259e, 16'h2d41, 16'h33c7, 16'h3906, 16'h3cde, 16'h3f36,
    16'h4000};

  typedef enum logic [3:0] {
    OP_GAIN, OP_PAN, OP_MUTE, OP_SOLO, OP_SOLO_EXCL, OP_MUTE_ALL,
    OP_SOLO_ALL, OP_MASTER, OP_BUS_MUTE, OP_PEAK_CLR
  } mmbe_op_type;

  typedef struct packed {
    mmbe_op_type op;
    logic [2:0]  pair;
    logic        side;     // Master gain: 0 left bus, 1 right bus
    logic [5:0]  chan;
    logic [15:0] value;
  } mmbe_cmd_type;

  typedef struct packed {
    logic [2:0]           pair;
    logic signed [SW-1:0] left;
    logic signed [SW-1:0] right;
  } mmbe_mix_type;

  typedef struct packed {
    logic [GW-1:0]      tgt;
    logic signed [16:0] step;
    logic [6:0]         cnt;
    logic [GW-1:0]      cur;
  } mmbe_ramp_type;
endpackage

// ==== verification/mmbe_chk.sv ====
/*
  Checker for the engine's frame timing, output stream and meter.
  Assumes it is bound to mmbe_engine and sees only its ports.
*/
`timescale 1ns/1ns
module mmbe_chk (
  // Clock and reset
  input wire logic                    REF_CLK,
  input wire logic                    RST,
  // Watched ports
  input wire logic                    SAMPLE_TICK,
  input wire logic                    MIX_VALID,
  input wire logic                    MIX_READY,
  input wire mmbe_pkg::mmbe_mix_type  MIX_WORD,
  input wire logic [5:0]              METER_SEL,
  input wire logic [mmbe_pkg::SW-1:0] METER_PEAK,
  input wire logic                    BUSY
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  logic [9:0] cnt_q, cnt_d;
  logic       stall_q, stall_d;
  logic [2:0] pair_q, pair_d;
  wire logic  take = MIX_VALID && MIX_READY;
  // Busy length, stall in frame, last pair taken
  always_comb begin
    cnt_d = BUSY ? cnt_q + 10'h001 : 10'h000;
    stall_d = BUSY && (stall_q || (MIX_VALID && !MIX_READY));
    pair_d = take ? MIX_WORD.pair : pair_q;
  end
  // Helper registers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cnt_q <= 10'h000;
      stall_q <= 1'b0;
      pair_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
      stall_q <= stall_d;
      pair_q <= pair_d;
    end
  end
  sequence s_accept; SAMPLE_TICK && !BUSY && !MIX_VALID; endsequence
  sequence s_quiet; !MIX_VALID [*8]; endsequence
  property p_rst_quiet;
    $fell(RST) |-> !MIX_VALID && !BUSY && METER_PEAK == '0;
  endproperty
  property p_accept; SAMPLE_TICK && !BUSY |=> BUSY; endproperty
  property p_idle; !BUSY && !SAMPLE_TICK |=> !BUSY; endproperty
  property p_first; s_accept |=> s_quiet ##[29:992] MIX_VALID; endproperty
  property p_hold;
    MIX_VALID && !MIX_READY |=> MIX_VALID && $stable(MIX_WORD);
  endproperty
  property p_pair_lim; MIX_VALID |-> MIX_WORD.pair < 3'h5; endproperty
  property p_pair_seq;
    take && MIX_WORD.pair != 3'h0 |-> MIX_WORD.pair == pair_q + 3'h1;
  endproperty
  property p_frame_len;
    $fell(BUSY) && !stall_q |->
      cnt_q inside {[10'h046:10'h050], [10'h0b4:10'h0be]};
  endproperty
  property p_meter_off; METER_SEL > 6'h23 |=> METER_PEAK == '0; endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not quiet after reset");
  a_accept: assert property (p_accept)
    else $error("tick not taken");
  a_idle: assert property (p_idle)
    else $error("busy without tick");
  a_first: assert property (p_first)
    else $error("first word timing wrong");
  a_hold: assert property (p_hold)
    else $error("word changed under stall");
  a_pair_lim: assert property (p_pair_lim)
    else $error("pair out of range");
  a_pair_seq: assert property (p_pair_seq)
    else $error("pair order wrong");
  a_frame_len: assert property (p_frame_len)
    else $error("frame length wrong");
  a_meter_off: assert property (p_meter_off)
    else $error("meter nonzero for bad select");
endmodule
bind mmbe_engine mmbe_chk u_mmbe_chk (.REF_CLK(REF_CLK), .RST(RST),
  .SAMPLE_TICK(SAMPLE_TICK), .MIX_VALID(MIX_VALID), .MIX_READY(MIX_READY),
  .MIX_WORD(MIX_WORD), .METER_SEL(METER_SEL), .METER_PEAK(METER_PEAK),
  .BUSY(BUSY));

// ==== verification/mmbe_snk.sv ====
/*
  Consumer model of the mixed output stream, with stall control.
  Assumes the bench paces it through slow and hold.
*/
`timescale 1ns/1ns
module mmbe_snk (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst,
  // Pacing
  input wire logic                   slow,
  input wire logic                   hold,
  // Mix stream
  input wire logic                   mix_valid,
  input wire mmbe_pkg::mmbe_mix_type mix_word,
  output logic                       mix_ready
);
  logic signed [23:0] got_l [5];
  logic signed [23:0] got_r [5];
  int                 n_words = 0;
  logic               tog_q;
  // Alternate-cycle toggle for slow pacing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) tog_q <= 1'b0;
    else tog_q <= ~tog_q;
  end
  assign mix_ready = !hold && !(slow && tog_q);
  // Latest word of each bus pair
  always_ff @(posedge clk) begin
    if (!rst && mix_valid && mix_ready) begin
      got_l[mix_word.pair] <= mix_word.left;
      got_r[mix_word.pair] <= mix_word.right;
      n_words <= n_words + 1;
    end
  end
endmodule

// ==== verification/matrix_mix_bus_engine_tb.sv ====
/*
  Bench for the mix bus engine: stereo playback table, then reset,
  stall, meter, pan, mute, solo, bus mute and headroom tests.
  Assumes the checker is bound and mmbe_snk consumes the output.
*/
`timescale 1ns/1ns
module matrix_mix_bus_engine_tb;
  logic ref_clk, rst, tick, dbl, cmd_valid, slow, hold, mix_valid, busy;
  logic [863:0] smp;
  logic [17:0] link;
  logic [5:0] msel;
  logic [23:0] peak;
  logic mix_ready;
  mmbe_pkg::mmbe_cmd_type cmd;
  mmbe_pkg::mmbe_mix_type mix_word;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  // Playback pair rows: left in, right in, left out, right out
  logic [23:0] tbl [5][4] = '{'{24'h000001, 24'hffffff, 24'h000001,
    24'hffffff}, '{24'h7fffff, 24'h800000, 24'h7fffff, 24'h800000},
    '{24'h400000, 24'hc00000, 24'h400000, 24'hc00000}, '{24'h123456,
    24'hedcba9, 24'h123456, 24'hedcba9}, '{24'h000100, 24'h7ffffe,
    24'h000100, 24'h7ffffe}};
  // Command steps: op, channel, value, left out, right out
  logic [73:0] steps [10] = '{
    {mmbe_pkg::OP_MUTE, 6'h00, 16'h0000, 24'h0b5140, 24'h0b5040},
    {mmbe_pkg::OP_PAN, 6'h00, 16'h009c, 24'h100100, 24'h000000},
    {mmbe_pkg::OP_PAN, 6'h00, 16'h0064, 24'h000100, 24'h100000},
    {mmbe_pkg::OP_SOLO_EXCL, 6'h12, 16'h0000, 24'h000100, 24'h0},
    {mmbe_pkg::OP_SOLO_ALL, 6'h00, 16'h0000, 24'h000100, 24'h100000},
    {mmbe_pkg::OP_GAIN, 6'h00, 16'hffff, 24'h000100, 24'h329880},
    {mmbe_pkg::OP_SOLO, 6'h00, 16'h0001, 24'h000000, 24'h329880},
    {mmbe_pkg::OP_BUS_MUTE, 6'h00, 16'h0001, 24'h000000, 24'h0},
    {mmbe_pkg::OP_BUS_MUTE, 6'h00, 16'h0000, 24'h000000, 24'h329880},
    {mmbe_pkg::OP_MUTE_ALL, 6'h00, 16'h0001, 24'h000000, 24'h0}};
  mmbe_engine u_mmbe_engine (.REF_CLK(ref_clk), .RST(rst),
    .SAMPLE_TICK(tick), .CH_SAMPLES(smp), .DOUBLE_RATE(dbl),
    .STEREO_LINK(link), .CMD_VALID(cmd_valid), .CMD_WORD(cmd),
    .MIX_VALID(mix_valid), .MIX_READY(mix_ready), .MIX_WORD(mix_word),
    .METER_SEL(msel), .METER_PEAK(peak), .BUSY(busy));
  mmbe_snk u_mmbe_snk (.clk(ref_clk), .rst(rst), .slow(slow), .hold(hold),
    .mix_valid(mix_valid), .mix_word(mix_word), .mix_ready(mix_ready));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Ceiling on run length against a hang
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmd_go(input mmbe_pkg::mmbe_op_type op,
    input logic [5:0] ch, input logic [15:0] v);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd = '{op, 3'h0, 1'b0, ch, v};
    @(negedge ref_clk);
    cmd_valid = 1'b0;
  endtask
  // One frame, optionally with the consumer held from the tick for hc + 1 cycles
  task automatic frame(input int hc);
    int n0;
    int k;
    n0 = u_mmbe_snk.n_words;
    @(negedge ref_clk);
    hold = (hc != 0);
    tick = 1'b1;
    @(negedge ref_clk);
    tick = 1'b0;
    repeat (hc) @(negedge ref_clk);
    if (hc != 0) chk({23'h0, busy & mix_valid}, 24'h1);
    hold = 1'b0;
    for (k = 0; k < 2000 && (busy || mix_valid); k++) @(negedge ref_clk);
    chk(24'(u_mmbe_snk.n_words - n0), dbl ? 24'h2 : 24'h5);
  endtask
  initial begin
    int i;
    {rst, tick, dbl, cmd_valid, slow, hold} = 6'h20;
    smp = '0;
    link = 18'h03e00;
    msel = 6'h00;
    cmd = '0;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    slow = 1'b1;
    for (i = 0; i < 5; i++) begin
      smp = '0;
      smp[23:0] = 24'h123456;
      smp[(18 + 2 * i) * 24 +: 24] = tbl[i][0];
      smp[(19 + 2 * i) * 24 +: 24] = tbl[i][1];
      frame(0);
      chk(u_mmbe_snk.got_l[i], tbl[i][2]);
      chk(u_mmbe_snk.got_r[i], tbl[i][3]);
      chk(u_mmbe_snk.got_l[(i + 1) % 5], 24'h0);
      $display("row %0d done", i);
    end
    slow = 1'b0;
    tick = 1'b1;
    @(negedge ref_clk);
    tick = 1'b0;
    repeat (20) @(negedge ref_clk);
    rst = 1'b1;
    repeat (12) @(negedge ref_clk);
    chk({22'h0, mix_valid, busy}, 24'h0);
    rst = 1'b0;
    smp = '0;
    smp[23:0] = 24'h000300;
    smp[18 * 24 +: 24] = 24'hffec78;
    frame(400);
    chk(u_mmbe_snk.got_l[0], 24'hffec78);
    msel = 6'h12;
    repeat (2) @(negedge ref_clk);
    chk(peak, 24'h001388);
    msel = 6'h00;
    repeat (2) @(negedge ref_clk);
    chk(peak, 24'h000300);
    cmd_go(mmbe_pkg::OP_PEAK_CLR, 6'h00, 16'h0000);
    msel = 6'h24;
    repeat (3) @(negedge ref_clk);
    chk(peak, 24'h0);
    msel = 6'h00;
    repeat (2) @(negedge ref_clk);
    chk(peak, 24'h0);
    $display("reset, stall and meter done");
    dbl = 1'b1;
    link = 18'h00200;
    smp = '0;
    smp[23:0] = 24'h100000;
    smp[18 * 24 +: 24] = 24'h000100;
    for (i = 0; i < 10; i++) begin
      cmd_go(mmbe_pkg::mmbe_op_type'(steps[i][73:70]), steps[i][69:64],
        steps[i][63:48]);
      frame(0);
      if (i == 0) chk({23'h0, u_mmbe_snk.got_l[0] < 24'h0b5140}, 24'h1);
      repeat (66) frame(0);
      chk(u_mmbe_snk.got_l[0], steps[i][47:24]);
      chk(u_mmbe_snk.got_r[0], steps[i][23:0]);
      $display("step %0d done", i);
    end
    link = 18'h3ffff;
    for (i = 0; i < 16; i++) smp[i * 48 +: 24] = 24'h400000;
    cmd_go(mmbe_pkg::OP_SOLO, 6'h00, 16'h0000);
    cmd_go(mmbe_pkg::OP_GAIN, 6'h00, 16'h4000);
    cmd_go(mmbe_pkg::OP_MUTE_ALL, 6'h00, 16'h0000);
    cmd_go(mmbe_pkg::OP_MASTER, 6'h00, 16'h0400);
    repeat (67) frame(0);
    chk(u_mmbe_snk.got_l[0], 24'h400000);
    chk(u_mmbe_snk.got_r[0], 24'h0);
    $display("headroom done");
    tally_and_finish();
  end
endmodule
